// file: bench/smce_host_model.sv
// host side model: command word link and user data registers
`timescale 1ns/100ps
module smce_host_model
    import smce_pkg::*;
(
    input wire logic clk,
    input wire logic wordReady,
    input wire logic [7:0] regRdIdx,
    output logic wordValid,
    output smce_word_t wordIn,
    output logic [31:0] regRdData,
    output logic hung
);
    logic [31:0] userReg [0:255];

    // data register read, answered in the same cycle
    assign regRdData = userReg[regRdIdx];

    // quiet link and cleared registers at start
    initial begin
        wordValid = 1'b0;
        wordIn = '0;
        hung = 1'b0;
        for (int i = 0; i < 256; i++) begin
            userReg[i] = 32'h0;
        end
    end

    // offer one word, held until an edge takes it; words go in command order
    task automatic send(input logic src, input logic [15:0] data);
        int n;
        n = 0;
        wordValid = 1'b1;
        wordIn = '{fromHost: src, data: data};
        while (!wordReady && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 50) hung = 1'b1;
        @(posedge clk);
        #1;
    endtask : send

    // release the link; data shows the inverse so stale words never match
    task automatic idle();
        wordValid = 1'b0;
        wordIn.data = ~wordIn.data;
    endtask : idle
endmodule : smce_host_model

// file: bench/tb_smce_cmd_exec.sv
// self-checking bench for the motion command executor
`timescale 1ns/100ps
module tb_smce_cmd_exec
    import smce_pkg::*;
;
    typedef struct {
        logic [15:0] op;
        logic [31:0] pos;
        logic [31:0] a1;
        logic [31:0] a2;
        logic [31:0] tgt;
        logic nak;
        smce_kind_t kind;
    } smce_row_t;

    logic clk, resetn, wordValid, recoveryDesignated, keepDriverOpt, driverOnReq, stepModeReq, haltFlagClear;
    logic wordReady, ackPulse, nakPulse, moveStart, hardStop, programAbort, recoveryStart, gearActive;
    logic driverEnable, stepMode, hung;
    logic [31:0] currentTarget, regRdData;
    logic [7:0] regRdIdx;
    logic [15:0] statusWord;
    smce_word_t wordIn;
    smce_move_t moveCmd;
    smce_gear_t gearCmd;
    logic [15:0] w[$];
    int badCount = 0;
    int compares = 0;
    int ackN = 0, nakN = 0, moveN = 0, hsN = 0, abN = 0, recN = 0;
    int h0, p0, r0, m0;
    // move rows: opcode, position, arg1, arg2, expected target, refused, kind
    smce_row_t rows[8] = '{
        '{OP_ABS_TIMED, 32'h000000C8, 32'h00000053, 32'h0000208D, 32'h000000C8, 1'b0, MK_ABS_TIME},
        '{OP_ABS_TIMED, 32'hFFFFFF38, 32'h0000FFFE, 32'h00000002, 32'hFFFFFF38, 1'b0, MK_ABS_TIME},
        '{OP_ABS_TIMED, 32'h00000010, 32'h0000FFFF, 32'h00000010, 32'h0, 1'b1, MK_ABS_TIME},
        '{OP_ABS_TIMED, 32'h00000010, 32'h00000000, 32'h00000001, 32'h0, 1'b1, MK_ABS_TIME},
        '{OP_REL_TIMED, 32'h00000FA0, 32'h00000341, 32'h0000208D, 32'hFFFFFFA0, 1'b0, MK_REL_TIME},
        '{OP_REL_TIMED, 32'hFFFFF060, 32'h00000000, 32'h00000002, 32'hFFFFE060, 1'b0, MK_REL_TIME},
        '{OP_ABS_VEL, 32'h00000000, 32'h00000001, 32'h00000007, 32'h00000000, 1'b0, MK_ABS_VEL},
        '{OP_ABS_VEL, 32'h00000020, 32'h00000000, 32'h00000007, 32'h0, 1'b1, MK_ABS_VEL}
    };

    smce_cmd_exec DUT (.clk(clk), .resetn(resetn), .wordValid(wordValid), .wordIn(wordIn),
        .currentTarget(currentTarget), .regRdData(regRdData), .recoveryDesignated(recoveryDesignated),
        .keepDriverOpt(keepDriverOpt), .driverOnReq(driverOnReq), .stepModeReq(stepModeReq),
        .haltFlagClear(haltFlagClear), .wordReady(wordReady), .ackPulse(ackPulse), .nakPulse(nakPulse),
        .moveStart(moveStart), .moveCmd(moveCmd), .hardStop(hardStop), .programAbort(programAbort),
        .recoveryStart(recoveryStart), .gearActive(gearActive), .gearCmd(gearCmd), .regRdIdx(regRdIdx),
        .driverEnable(driverEnable), .stepMode(stepMode), .statusWord(statusWord));

    smce_host_model host (.clk(clk), .wordReady(wordReady), .regRdIdx(regRdIdx), .wordValid(wordValid),
        .wordIn(wordIn), .regRdData(regRdData), .hung(hung));

    // clock generator
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // pulse tallies taken mid-cycle where outputs are settled
    always @(negedge clk) begin
        ackN += ackPulse;
        nakN += nakPulse;
        moveN += moveStart;
        hsN += hardStop;
        abN += programAbort;
        recN += recoveryStart;
    end

    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, badCount);
        if (badCount == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            badCount++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    // send the words in w and wait a bounded time for the answer
    task automatic run(input logic src, input logic expNak);
        int a0, k0, n;
        a0 = ackN;
        k0 = nakN;
        n = 0;
        @(posedge clk);
        #1;
        foreach (w[i]) host.send(src, w[i]);
        host.idle();
        while (ackN + nakN == a0 + k0 && n < 10) begin
            @(negedge clk);
            n++;
        end
        if (n == 10) begin
            badCount++;
            summarize();
        end else begin
            // back on the drive point just after a rising edge
            @(posedge clk);
            #1;
            check(nakN - k0, expNak);
            check(ackN - a0, !expNak);
        end
    endtask : run

    // one-cycle pulse on driver-on, step-on and flag-clear requests
    task automatic strobe(input logic [2:0] s);
        {driverOnReq, stepModeReq, haltFlagClear} = s;
        @(posedge clk);
        #1;
        {driverOnReq, stepModeReq, haltFlagClear} = 3'h0;
    endtask : strobe

    // main sequence
    initial begin
        resetn = 1'b0;
        {recoveryDesignated, keepDriverOpt, driverOnReq, stepModeReq, haltFlagClear} = 5'h10;
        currentTarget = 32'hFFFFF000;
        repeat (12) @(posedge clk);
        #1;
        check({wordReady, ackPulse, nakPulse, moveStart, hardStop, gearActive, driverEnable, stepMode,
            statusWord}, 24'h800000);
        resetn = 1'b1;
        $display("reset test done");
        foreach (rows[i]) begin
            m0 = moveN;
            w = {rows[i].op, rows[i].pos[31:16], rows[i].pos[15:0], rows[i].a1[31:16], rows[i].a1[15:0],
                rows[i].a2[31:16], rows[i].a2[15:0], 16'h00A5, 16'h005A};
            run(1'b0, rows[i].nak);
            check(moveN - m0, !rows[i].nak);
            if (!rows[i].nak) begin
                check({moveCmd.kind, moveCmd.target}, {rows[i].kind, rows[i].tgt});
                check({moveCmd.arg1, moveCmd.arg2}, {rows[i].a1, rows[i].a2});
                check({moveCmd.stopEn, moveCmd.stopState}, 32'h00A5005A);
            end
            $display("move row %0d done", i);
        end
        // gearing with ratio 3, then ratio 2 while running
        host.userReg[21] = 32'h00000064;
        host.userReg[22] = 32'h01C9C380;
        w = {OP_GEAR, 16'h0008, 16'h0015, 16'h0003, 16'h0001};
        run(1'b0, 1'b0);
        repeat (4) @(posedge clk);
        #1;
        check({gearActive, gearCmd.mode, gearCmd.stopEn, gearCmd.stopState}, 49'h1000800030001);
        check({gearCmd.accelFactor, gearCmd.scaleFactor}, 64'h0000006401C9C380);
        host.userReg[22] = 32'h01312D00;
        repeat (4) @(posedge clk);
        #1;
        check(gearCmd.scaleFactor, 32'h01312D00);
        h0 = hsN;
        w = {OP_HSTOP};
        run(1'b0, 1'b0);
        check({hsN - h0, gearActive}, 2'h2);
        w = {OP_GEAR, 16'h0008, 16'h000A, 16'h0000, 16'h0000};
        run(1'b0, 1'b1);
        // gearing left running so the halt below has to end it
        w = {OP_GEAR, 16'h0008, 16'h0015, 16'h0003, 16'h0001};
        run(1'b0, 1'b0);
        $display("gearing and abrupt stop test done");
        // host halt with driver on and step mode on, driver not kept
        strobe(3'h6);
        check({driverEnable, stepMode}, 2'h3);
        {h0, p0, r0} = {hsN, abN, recN};
        w = {OP_HALT};
        run(1'b1, 1'b0);
        check({statusWord, stepMode, driverEnable, gearActive}, 19'h02000);
        repeat (2) @(posedge clk);
        #1;
        check(hsN - h0, 32'd1);
        check({abN - p0, recN - r0}, {32'd1, 32'd1});
        // second halt keeps the driver when both options are on
        keepDriverOpt = 1'b1;
        strobe(3'h5);
        w = {OP_HALT};
        run(1'b1, 1'b0);
        check({statusWord, driverEnable}, 17'h00801);
        // halt from a program is refused and changes nothing
        strobe(3'h1);
        h0 = hsN;
        w = {OP_HALT};
        run(1'b0, 1'b1);
        check({statusWord, hsN - h0}, 48'h0);
        w = {16'h0001};
        run(1'b1, 1'b1);
        $display("halt test done");
        // reset in mid-run
        resetn = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check({wordReady, gearActive, driverEnable, stepMode, statusWord}, 20'h80000);
        resetn = 1'b1;
        // first command straight after release is taken
        w = {OP_HSTOP};
        run(1'b1, 1'b0);
        check(hung, 1'b0);
        $display("second reset test done");
        summarize();
    end
endmodule : tb_smce_cmd_exec

// file: include/smce_pkg.sv
// constants and carrier types for the servo motion command executor
package smce_pkg;
    // opcodes
    localparam logic [15:0] OP_GEAR = 16'h005D;
    localparam logic [15:0] OP_HALT = 16'h0002;
    localparam logic [15:0] OP_HSTOP = 16'h00E5;
    localparam logic [15:0] OP_ABS_TIMED = 16'h00B0;
    localparam logic [15:0] OP_ABS_VEL = 16'h0086;
    localparam logic [15:0] OP_REL_TIMED = 16'h00B1;
    // parameter words following each multi-word opcode
    localparam logic [3:0] GEAR_PARAMS = 4'h4;
    localparam logic [3:0] MOVE_PARAMS = 4'h8;
    localparam int PARAM_DEPTH = 8;
    // parameter word positions
    localparam int PW_POS_HI = 0;
    localparam int PW_POS_LO = 1;
    localparam int PW_A1_HI = 2;
    localparam int PW_A1_LO = 3;
    localparam int PW_A2_HI = 4;
    localparam int PW_A2_LO = 5;
    localparam int PW_MV_SEN = 6;
    localparam int PW_MV_SST = 7;
    localparam int PW_G_MODE = 0;
    localparam int PW_G_BASE = 1;
    localparam int PW_G_SEN = 2;
    localparam int PW_G_SST = 3;
    // parameter limits
    localparam logic [31:0] ACC_TIME_MAX = 32'h0000FFFE;
    localparam logic [31:0] TOTAL_TIME_MIN = 32'h00000002;
    localparam logic [31:0] ACCEL_MIN = 32'h00000001;
    localparam logic [15:0] GEAR_BASE_MIN = 16'h000B;
    localparam logic [15:0] GEAR_BASE_MAX = 16'h00C6;
    // status word and gearing register index step
    localparam int STAT_HALT_BIT = 10;
    localparam logic [15:0] STAT_RESET = 16'h0000;
    localparam logic [7:0] IDX_ONE = 8'h01;

    typedef enum logic [1:0] {
        MK_ABS_TIME = 2'h0,
        MK_REL_TIME = 2'h1,
        MK_ABS_VEL = 2'h2
    } smce_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_COLLECT = 2'b01,
        ST_EXEC = 2'b11,
        ST_HALT = 2'b10
    } smce_state_t;

    typedef struct packed {
        logic fromHost;
        logic [15:0] data;
    } smce_word_t;

    typedef struct packed {
        smce_kind_t kind;
        logic [31:0] target;
        logic [31:0] arg1;
        logic [31:0] arg2;
        logic [15:0] stopEn;
        logic [15:0] stopState;
    } smce_move_t;

    typedef struct packed {
        logic [15:0] mode;
        logic [31:0] accelFactor;
        logic [31:0] scaleFactor;
        logic [15:0] stopEn;
        logic [15:0] stopState;
    } smce_gear_t;
endpackage : smce_pkg

// file: rtl/smce_cmd_exec.sv
// motion command decoder and executor
`timescale 1ns/100ps
module smce_cmd_exec
    import smce_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic wordValid,
    input wire smce_word_t wordIn,
    input wire logic [31:0] currentTarget,
    input wire logic [31:0] regRdData,
    input wire logic recoveryDesignated,
    input wire logic keepDriverOpt,
    input wire logic driverOnReq,
    input wire logic stepModeReq,
    input wire logic haltFlagClear,
    output logic wordReady,
    output logic ackPulse,
    output logic nakPulse,
    output logic moveStart,
    output smce_move_t moveCmd,
    output logic hardStop,
    output logic programAbort,
    output logic recoveryStart,
    output logic gearActive,
    output smce_gear_t gearCmd,
    output logic [7:0] regRdIdx,
    output logic driverEnable,
    output logic stepMode,
    output logic [15:0] statusWord
);
    smce_state_t state_reg;
    logic [15:0] opcode_reg;
    logic [3:0] remain_reg;
    logic gearSel_reg;
    logic [7:0] gearBase_reg;
    logic [PARAM_DEPTH-1:0][15:0] params;

    // join high then low word
    function automatic logic [31:0] w32(input logic [15:0] hi, input logic [15:0] lo);
        w32 = {hi, lo};
    endfunction : w32

    // decoded events of the current cycle
    logic takeWord;
    logic haltNow;
    logic hstopNow;
    logic startMulti;
    logic badFirst;
    logic lastParam;
    logic moveOk;
    logic gearOk;
    assign takeWord = wordValid && wordReady;
    assign haltNow = takeWord && state_reg == ST_IDLE && wordIn.data == OP_HALT && wordIn.fromHost;
    assign hstopNow = takeWord && state_reg == ST_IDLE && wordIn.data == OP_HSTOP;
    assign startMulti = takeWord && state_reg == ST_IDLE &&
        (wordIn.data == OP_GEAR || wordIn.data == OP_ABS_TIMED ||
        wordIn.data == OP_ABS_VEL || wordIn.data == OP_REL_TIMED);
    assign badFirst = takeWord && state_reg == ST_IDLE && !haltNow && !hstopNow && !startMulti;
    assign lastParam = takeWord && state_reg == ST_COLLECT && remain_reg == 4'h1;
    // range checks on the collected parameters
    always_comb begin
        moveOk = 1'b1;
        if (opcode_reg == OP_ABS_TIMED || opcode_reg == OP_REL_TIMED) begin
            moveOk = w32(params[PW_A1_HI], params[PW_A1_LO]) <= ACC_TIME_MAX &&
                w32(params[PW_A2_HI], params[PW_A2_LO]) >= TOTAL_TIME_MIN;
        end else if (opcode_reg == OP_ABS_VEL) begin
            moveOk = w32(params[PW_A1_HI], params[PW_A1_LO]) >= ACCEL_MIN;
        end
    end
    assign gearOk = params[PW_G_BASE] >= GEAR_BASE_MIN && params[PW_G_BASE] <= GEAR_BASE_MAX;

    smce_param_collect u_collect (
        .clk(clk),
        .resetn(resetn),
        .clear(startMulti),
        .wordStrobe(takeWord && state_reg == ST_COLLECT),
        .wordData(wordIn.data),
        .params(params)
    );

    // command sequencing
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            opcode_reg <= 16'h0000;
            remain_reg <= 4'h0;
            wordReady <= 1'b1;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (haltNow) begin
                        state_reg <= ST_HALT;
                        wordReady <= 1'b0;
                    end else if (startMulti) begin
                        state_reg <= ST_COLLECT;
                        opcode_reg <= wordIn.data;
                        remain_reg <= (wordIn.data == OP_GEAR) ? GEAR_PARAMS : MOVE_PARAMS;
                    end
                end
                ST_COLLECT: begin
                    if (takeWord) begin
                        remain_reg <= remain_reg - 4'h1;
                    end
                    if (lastParam) begin
                        state_reg <= ST_EXEC;
                        wordReady <= 1'b0;
                    end
                end
                ST_EXEC, ST_HALT: begin
                    state_reg <= ST_IDLE;
                    wordReady <= 1'b1;
                end
                default: begin
                    state_reg <= ST_IDLE;
                    wordReady <= 1'b1;
                end
            endcase
        end
    end

    // answers: bare acknowledge or refusal, never data
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ackPulse <= 1'b0;
            nakPulse <= 1'b0;
        end else begin
            ackPulse <= haltNow || hstopNow ||
                (state_reg == ST_EXEC && (opcode_reg == OP_GEAR ? gearOk : moveOk));
            nakPulse <= badFirst ||
                (state_reg == ST_EXEC && !(opcode_reg == OP_GEAR ? gearOk : moveOk));
        end
    end

    // move launch toward the trajectory generator
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            moveStart <= 1'b0;
            moveCmd <= '0;
        end else begin
            moveStart <= state_reg == ST_EXEC && opcode_reg != OP_GEAR && moveOk;
            if (state_reg == ST_EXEC && opcode_reg != OP_GEAR) begin
                moveCmd.kind <= opcode_reg == OP_ABS_TIMED ? MK_ABS_TIME :
                    (opcode_reg == OP_REL_TIMED ? MK_REL_TIME : MK_ABS_VEL);
                moveCmd.target <= (opcode_reg == OP_REL_TIMED) ?
                    currentTarget + w32(params[PW_POS_HI], params[PW_POS_LO]) :
                    w32(params[PW_POS_HI], params[PW_POS_LO]);
                moveCmd.arg1 <= w32(params[PW_A1_HI], params[PW_A1_LO]);
                moveCmd.arg2 <= w32(params[PW_A2_HI], params[PW_A2_LO]);
                moveCmd.stopEn <= params[PW_MV_SEN];
                moveCmd.stopState <= params[PW_MV_SST];
            end
        end
    end

    // stop pulses and recovery launch
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hardStop <= 1'b0;
            programAbort <= 1'b0;
            recoveryStart <= 1'b0;
        end else begin
            hardStop <= haltNow || hstopNow;
            programAbort <= haltNow;
            recoveryStart <= state_reg == ST_HALT;
        end
    end

    // gearing mode: set up, then poll registers N and N+1 every other cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gearActive <= 1'b0;
            gearCmd <= '0;
            gearBase_reg <= 8'h00;
            gearSel_reg <= 1'b0;
            regRdIdx <= 8'h00;
        end else if (haltNow || hstopNow || moveStart) begin
            gearActive <= 1'b0;
        end else if (state_reg == ST_EXEC && opcode_reg == OP_GEAR && gearOk) begin
            gearActive <= 1'b1;
            gearCmd.mode <= params[PW_G_MODE];
            gearCmd.stopEn <= params[PW_G_SEN];
            gearCmd.stopState <= params[PW_G_SST];
            gearBase_reg <= params[PW_G_BASE][7:0];
            regRdIdx <= params[PW_G_BASE][7:0];
            gearSel_reg <= 1'b0;
        end else if (gearActive) begin
            if (gearSel_reg) begin
                gearCmd.scaleFactor <= regRdData;
            end else begin
                gearCmd.accelFactor <= regRdData;
            end
            gearSel_reg <= !gearSel_reg;
            regRdIdx <= gearSel_reg ? gearBase_reg : gearBase_reg + IDX_ONE;
        end
    end

    // driver enable, step mode and status word
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            driverEnable <= 1'b0;
            stepMode <= 1'b0;
            statusWord <= STAT_RESET;
        end else begin
            if (haltNow) begin
                driverEnable <= driverEnable && recoveryDesignated && keepDriverOpt;
            end else if (driverOnReq) begin
                driverEnable <= 1'b1;
            end
            if (haltNow) begin
                stepMode <= 1'b0;
            end else if (stepModeReq) begin
                stepMode <= 1'b1;
            end
            if (haltNow) begin
                statusWord[STAT_HALT_BIT] <= 1'b1;
            end else if (haltFlagClear) begin
                statusWord[STAT_HALT_BIT] <= 1'b0;
            end
        end
    end

    // checks
    property p_halt_seq;
        @(posedge clk) disable iff (!resetn) haltNow |=> hardStop && programAbort ##1 recoveryStart;
    endproperty
    a_halt_seq: assert property (p_halt_seq) else $error("halt sequence wrong");
    property p_halt_status;
        @(posedge clk) disable iff (!resetn) haltNow |=> statusWord[STAT_HALT_BIT] && !stepMode;
    endproperty
    a_halt_status: assert property (p_halt_status) else $error("halt status or step wrong");
    property p_halt_drv;
        @(posedge clk) disable iff (!resetn) haltNow && !(recoveryDesignated && keepDriverOpt) |=> !driverEnable;
    endproperty
    a_halt_drv: assert property (p_halt_drv) else $error("driver left on after halt");
    property p_halt_ends;
        @(posedge clk) disable iff (!resetn) haltNow |=> !gearActive && !moveStart;
    endproperty
    a_halt_ends: assert property (p_halt_ends) else $error("activity after halt");
    property p_halt_host;
        @(posedge clk) disable iff (!resetn)
            takeWord && state_reg == ST_IDLE && wordIn.data == OP_HALT && !wordIn.fromHost |=> nakPulse && !hardStop;
    endproperty
    a_halt_host: assert property (p_halt_host) else $error("program halt accepted");
    property p_hstop;
        @(posedge clk) disable iff (!resetn) hstopNow |=> hardStop && ackPulse && !gearActive;
    endproperty
    a_hstop: assert property (p_hstop) else $error("abrupt stop missed");
    property p_rel;
        @(posedge clk) disable iff (!resetn) state_reg == ST_EXEC && opcode_reg == OP_REL_TIMED && moveOk |=>
            moveStart && moveCmd.target == $past(currentTarget) + $past(w32(params[PW_POS_HI], params[PW_POS_LO]));
    endproperty
    a_rel: assert property (p_rel) else $error("relative target wrong");
    property p_timed_range;
        @(posedge clk) disable iff (!resetn) moveStart && moveCmd.kind != MK_ABS_VEL |->
            moveCmd.arg1 <= ACC_TIME_MAX && moveCmd.arg2 >= TOTAL_TIME_MIN;
    endproperty
    a_timed_range: assert property (p_timed_range) else $error("timed move out of range");
    property p_vel_range;
        @(posedge clk) disable iff (!resetn) moveStart && moveCmd.kind == MK_ABS_VEL |-> moveCmd.arg1 >= ACCEL_MIN;
    endproperty
    a_vel_range: assert property (p_vel_range) else $error("velocity move accel zero");
    // polling only; stops, a move launch and a fresh gearing set-up take the cycle instead
    property p_gear_poll;
        @(posedge clk) disable iff (!resetn) gearActive && $past(gearActive) && !gearSel_reg &&
            !haltNow && !hstopNow && !moveStart && !(state_reg == ST_EXEC && opcode_reg == OP_GEAR && gearOk) |=>
            gearCmd.accelFactor == $past(regRdData) && regRdIdx == gearBase_reg + IDX_ONE;
    endproperty
    a_gear_poll: assert property (p_gear_poll) else $error("gearing poll wrong");
    property p_gear_len;
        @(posedge clk) disable iff (!resetn) startMulti && wordIn.data == OP_GEAR |=> remain_reg == GEAR_PARAMS;
    endproperty
    a_gear_len: assert property (p_gear_len) else $error("gearing length wrong");
    property p_ack_excl;
        @(posedge clk) disable iff (!resetn) !(ackPulse && nakPulse);
    endproperty
    a_ack_excl: assert property (p_ack_excl) else $error("ack and nak together");
    c_halt: cover property (@(posedge clk) disable iff (!resetn) haltNow ##2 recoveryStart);
    c_move: cover property (@(posedge clk) disable iff (!resetn) moveStart && moveCmd.kind == MK_REL_TIME);
    c_gear: cover property (@(posedge clk) disable iff (!resetn) gearActive ##4 gearActive);
    c_nak: cover property (@(posedge clk) disable iff (!resetn) nakPulse);
endmodule : smce_cmd_exec

// file: rtl/smce_param_collect.sv
// parameter word store for one command
`timescale 1ns/100ps
module smce_param_collect
    import smce_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic clear,
    input wire logic wordStrobe,
    input wire logic [15:0] wordData,
    output logic [PARAM_DEPTH-1:0][15:0] params
);
    logic [2:0] wrIdx_reg;

    // write index, restarted for each new command
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrIdx_reg <= 3'h0;
        end else if (clear) begin
            wrIdx_reg <= 3'h0;
        end else if (wordStrobe) begin
            wrIdx_reg <= wrIdx_reg + 3'h1;
        end
    end

    // word storage in flip-flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            params <= '0;
        end else if (wordStrobe && !clear) begin
            params[wrIdx_reg] <= wordData;
        end
    end
endmodule : smce_param_collect
